/* File: design/mpdb_conv_decode.sv */
/*
 Decodes control and alert fields into conversion configuration.
 Purely combinational; feeds registered state in the main module.
*/
`timescale 1ns/1ps
`include "mpdb_defs.svh"

module mpdb_conv_decode (
  input wire logic [15:0] control,
  input wire logic [15:0] alert,
  output mpdb_pkg::mpdb_conv_cfg_s cfg
);
  mpdb_pkg::mpdb_conv_e sel;
  logic [1:0] acq;
  logic [1:0] texc;

  always_comb begin
    sel = mpdb_pkg::mpdb_conv_e'(
      control[`MPDB_CTL_CONV_HI:`MPDB_CTL_CONV_LO]);
    acq = control[`MPDB_CTL_ACQ_HI:`MPDB_CTL_ACQ_LO];
    texc = alert[`MPDB_ALR_TEXC_HI:`MPDB_ALR_TEXC_LO];
    cfg = '0;
    cfg.volt_en = 6'h3f; // [R01]
    case (sel) // [R04] [R05]
      mpdb_pkg::MPDB_CONV_ALL: begin
        cfg.temp_en = 6'h3f;
        cfg.conv_count = 4'hc;
      end
      mpdb_pkg::MPDB_CONV_ODD: begin
        cfg.temp_en = 6'h15;
        cfg.conv_count = 4'h9;
      end
      mpdb_pkg::MPDB_CONV_VOLT: begin
        cfg.conv_count = 4'h6;
      end
      mpdb_pkg::MPDB_CONV_SELF: begin
        cfg.volt_en = 6'h00;
        cfg.self_test = 1'b1;
        cfg.conv_count = 4'h1;
      end
      default: begin
        cfg.conv_count = 4'h0;
      end
    endcase
    // Acquisition is (field+1) steps of 400 ns in core clocks
    cfg.acq_cycles = 6'((32'(acq) + 32'h1) * `MPDB_ACQ_STEP_NS
      / `MPDB_CLK_NS); // [R11]
    cfg.temp_alert_en = cfg.temp_en;
    case (texc) // [R08]
      2'b01: cfg.temp_alert_en = cfg.temp_en & 6'h2f;
      2'b10: cfg.temp_alert_en = cfg.temp_en & 6'h2b;
      default: cfg.temp_alert_en = cfg.temp_en;
    endcase
    cfg.term_en = control[`MPDB_CTL_TERM];
  end
endmodule

/* File: design/mpdb_defs.svh */
/*
 Constant definitions for the monitor power-down and balance control block.
 Assumes a 10 MHz core clock; included by bare name.
*/
`ifndef MPDB_DEFS_SVH
`define MPDB_DEFS_SVH

// Register indices
`define MPDB_ADDR_CONTROL 4'hd
`define MPDB_ADDR_ALERT 4'he
`define MPDB_ADDR_BALANCE 4'h1
`define MPDB_ADDR_PDTIMER 4'h2
`define MPDB_ADDR_STATUS 4'h3

// Control field positions
`define MPDB_CTL_CONV_HI 15
`define MPDB_CTL_CONV_LO 14
`define MPDB_CTL_RDBK_HI 13
`define MPDB_CTL_RDBK_LO 12
`define MPDB_CTL_SWPD 8
`define MPDB_CTL_ACQ_HI 6
`define MPDB_CTL_ACQ_LO 5
`define MPDB_CTL_TERM 3

// Alert field positions
`define MPDB_ALR_TEXC_HI 1
`define MPDB_ALR_TEXC_LO 0

// Delay timer field positions
`define MPDB_PDT_HI 4
`define MPDB_PDT_LO 0

// Reset values
`define MPDB_CONTROL_RST 16'h0000
`define MPDB_ALERT_RST 16'h0000
`define MPDB_BALANCE_RST 6'h00
`define MPDB_PDTIMER_RST 5'h00

// Timing
`define MPDB_CLK_HZ 10000000
`define MPDB_MINUTE_S 60
`define MPDB_MINUTE_CYC (`MPDB_CLK_HZ * `MPDB_MINUTE_S)
`define MPDB_ACQ_STEP_NS 400
`define MPDB_CLK_NS 100

`endif

/* File: design/mpdb_minute_tick.sv */
/*
 Minute tick generator: one-cycle pulse once per minute of core_clk.
 Assumes clear is held while the delay is not running.
*/
`timescale 1ns/1ps
`include "mpdb_defs.svh"

module mpdb_minute_tick #(
  parameter int unsigned CYCLES = `MPDB_MINUTE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clear,
  output logic tick
);
  typedef struct packed {
    logic [29:0] cnt;
    logic tick;
  } mpdb_tick_s;

  mpdb_tick_s st;
  mpdb_tick_s next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (clear) begin
      next_st.cnt = '0;
    end else if (st.cnt == 30'(CYCLES - 1)) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 30'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule

/* File: design/mpdb_pkg.sv */
/*
 Types for the monitor power-down and balance control block.
 Assumes mpdb_defs.svh is compiled alongside.
*/
package mpdb_pkg;
  typedef enum logic [1:0] {
    MPDB_RUN = 2'b00,
    MPDB_DELAY = 2'b01,
    MPDB_SW_DOWN = 2'b10,
    MPDB_FULL_DOWN = 2'b11
  } mpdb_pwr_e;

  typedef enum logic [1:0] {
    MPDB_CONV_ALL = 2'b00,
    MPDB_CONV_ODD = 2'b01,
    MPDB_CONV_VOLT = 2'b10,
    MPDB_CONV_SELF = 2'b11
  } mpdb_conv_e;

  typedef struct packed {
    logic [5:0] volt_en;
    logic [5:0] temp_en;
    logic [5:0] temp_alert_en;
    logic self_test;
    logic [3:0] conv_count;
    logic [5:0] acq_cycles;
    logic term_en;
  } mpdb_conv_cfg_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } mpdb_bus_s;
endpackage

/* File: design/mpdb_power_ctrl.sv */
/*
 Power-down sequencing, delay timer and cell-balance gate control.
 Assumes a synchronous register port and synchronous pin inputs.
*/
`timescale 1ns/1ps
`include "mpdb_defs.svh"

// Functional notes
// [R01] All six voltage channels are converted on every request; self-test mode (11) clears volt_en instead.
// [R02] Host discards results of voltage channels it does not use.
// [R03] Host sets alert exclusions so shorted channels raise no alert.
// [R04] Control D15:D14 selects how many temperature channels convert.
// [R05] 00 all, 01 temps 1/3/5, 10 voltages only, 11 self-test.
// [R06] Control D13:D12 sets how many results are offered for readback.
// [R07] Host writes D15,D13 zero and D14,D12 one for few temps.
// [R08] Alert D1:D0 drops temp five, or five and three, from faults.
// [R09] Host sets control D3 when shared thermistor termination used.
// [R10] Host enables termination only with 1.6 us acquisition.
// [R11] D6:D5 selects 400/800/1200/1600 ns acquisition; reset 400 ns.
// [R12] Falling edge on power-down pin gives full power-down.
// [R13] Writing one to control D8 requests software power-down.
// [R14] Software power-down keeps regulator and daisy chain alive.
// [R15] Delay timer programmable 0 to 31 minutes, one-minute steps.
// [R16] Pin edge or D8 starts the timer; power-down at expiry.
// [R17] Host loads the delay before triggering power-down.
// [R18] Delay register resets to zero, making power-down immediate.
// [R19] Host waits 5 ms after full power-down before converting.
// [R20] Six balance gate outputs follow cell-balance register bits.
// [R21] Cell-balance register resets to zero, all gates off.
// [R22] Zero delay turns gates off at once; else at expiry.
// [R23] Timer counts minute ticks and requests power-down at match.
module mpdb_power_ctrl #(
  parameter int unsigned MINUTE_CYCLES = `MPDB_MINUTE_CYC,
  parameter int unsigned CELLS = 6
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic power_down_pin_n,
  output logic [CELLS-1:0] balance_gate_output,
  output logic analog_enable,
  output logic digital_enable,
  output logic regulator_enable,
  output logic chain_enable,
  output logic thermistor_termination_input_en,
  output logic [1:0] readback_select,
  output mpdb_pkg::mpdb_conv_cfg_s conv_cfg
);
  typedef struct packed {
    logic [15:0] control;
    logic [15:0] alert;
    logic [CELLS-1:0] balance;
    logic [4:0] shutdown_delay_timer;
    logic [4:0] minutes;
    mpdb_pkg::mpdb_pwr_e pwr;
    logic full_req;
    logic pin_q;
    logic [15:0] rdata;
    mpdb_pkg::mpdb_conv_cfg_s cfg;
  } mpdb_state_s;

  mpdb_state_s st;
  mpdb_state_s next_st;
  mpdb_pkg::mpdb_conv_cfg_s dec_cfg;
  logic tick;
  logic timer_clear;
  logic pin_fall;
  logic swpd_set;
  logic trigger;

  ////////////////////////////////////////////////////////////////////////
  mpdb_conv_decode u_decode (
    .control(st.control),
    .alert(st.alert),
    .cfg(dec_cfg)
  );

  assign timer_clear = (st.pwr != mpdb_pkg::MPDB_DELAY);

  mpdb_minute_tick #(
    .CYCLES(MINUTE_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(timer_clear),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  assign pin_fall = st.pin_q & ~power_down_pin_n; // [R12]
  assign swpd_set = reg_wr && (reg_addr == `MPDB_ADDR_CONTROL) &&
    reg_wdata[`MPDB_CTL_SWPD] && !st.control[`MPDB_CTL_SWPD]; // [R13]
  assign trigger = pin_fall | swpd_set;

  always_comb begin
    next_st = st;
    next_st.pin_q = power_down_pin_n;
    next_st.cfg = dec_cfg;
    next_st.rdata = 16'h0000;
    if (reg_wr) begin
      case (reg_addr)
        `MPDB_ADDR_CONTROL: next_st.control = reg_wdata;
        `MPDB_ADDR_ALERT: next_st.alert = reg_wdata;
        `MPDB_ADDR_BALANCE: next_st.balance = reg_wdata[CELLS-1:0]; // [R20]
        `MPDB_ADDR_PDTIMER:
          next_st.shutdown_delay_timer =
            reg_wdata[`MPDB_PDT_HI:`MPDB_PDT_LO]; // [R15]
        default: next_st.control = st.control;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `MPDB_ADDR_CONTROL: next_st.rdata = st.control;
        `MPDB_ADDR_ALERT: next_st.rdata = st.alert;
        `MPDB_ADDR_BALANCE: next_st.rdata = 16'(st.balance);
        `MPDB_ADDR_PDTIMER: next_st.rdata = 16'(st.shutdown_delay_timer);
        `MPDB_ADDR_STATUS: next_st.rdata = {8'h00, st.minutes,
          st.full_req, st.pwr};
        default: next_st.rdata = 16'h0000;
      endcase
    end
    case (st.pwr)
      mpdb_pkg::MPDB_RUN: begin
        if (trigger) begin
          next_st.full_req = pin_fall;
          next_st.minutes = 5'h00;
          if (st.shutdown_delay_timer == `MPDB_PDTIMER_RST) begin // [R18]
            next_st.balance = '0; // [R22]
            next_st.pwr = pin_fall ? mpdb_pkg::MPDB_FULL_DOWN
              : mpdb_pkg::MPDB_SW_DOWN;
          end else begin
            next_st.pwr = mpdb_pkg::MPDB_DELAY; // [R16]
          end
        end
      end
      mpdb_pkg::MPDB_DELAY: begin
        if (pin_fall) begin
          next_st.full_req = 1'b1;
        end
        if (tick) begin
          next_st.minutes = st.minutes + 5'h01; // [R23]
        end
        if (tick && (st.minutes + 5'h01 == st.shutdown_delay_timer)) begin
          next_st.balance = '0; // [R22]
          next_st.pwr = (st.full_req || pin_fall) ?
            mpdb_pkg::MPDB_FULL_DOWN : mpdb_pkg::MPDB_SW_DOWN; // [R16]
        end
      end
      mpdb_pkg::MPDB_SW_DOWN: begin
        // Wake by clearing the power-down bit over the chain
        if (reg_wr && reg_addr == `MPDB_ADDR_CONTROL &&
            !reg_wdata[`MPDB_CTL_SWPD]) begin
          next_st.pwr = mpdb_pkg::MPDB_RUN;
        end else if (pin_fall) begin
          next_st.pwr = mpdb_pkg::MPDB_FULL_DOWN;
        end
      end
      mpdb_pkg::MPDB_FULL_DOWN: begin
        // Only a pin release brings the part back
        if (power_down_pin_n && st.pin_q) begin
          next_st.pwr = mpdb_pkg::MPDB_RUN;
          next_st.full_req = 1'b0;
        end
      end
      default: next_st.pwr = mpdb_pkg::MPDB_RUN;
    endcase
    if (next_st.pwr == mpdb_pkg::MPDB_SW_DOWN ||
        next_st.pwr == mpdb_pkg::MPDB_FULL_DOWN) begin
      next_st.balance = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.control <= `MPDB_CONTROL_RST; // [R11]
      st.alert <= `MPDB_ALERT_RST;
      st.balance <= '0; // [R21]
      st.shutdown_delay_timer <= `MPDB_PDTIMER_RST; // [R18]
      st.minutes <= 5'h00;
      st.pwr <= mpdb_pkg::MPDB_RUN;
      st.full_req <= 1'b0;
      st.pin_q <= 1'b1;
      st.rdata <= 16'h0000;
      st.cfg <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign reg_rdata = st.rdata;
  assign balance_gate_output = st.balance; // [R20]
  assign analog_enable = (st.pwr == mpdb_pkg::MPDB_RUN) ||
    (st.pwr == mpdb_pkg::MPDB_DELAY);
  assign digital_enable = analog_enable;
  // Regulator and chain stay up in software power-down for wake-up
  assign regulator_enable = (st.pwr != mpdb_pkg::MPDB_FULL_DOWN); // [R14]
  assign chain_enable = regulator_enable; // [R14]
  assign thermistor_termination_input_en = st.cfg.term_en;
  assign readback_select =
    st.control[`MPDB_CTL_RDBK_HI:`MPDB_CTL_RDBK_LO]; // [R06]
  assign conv_cfg = st.cfg;
endmodule

/* File: sim/mpdb_host_model.sv */
/*
 Host model: drives the register port and the power-down pin.
 Assumes the bench calls its tasks from one process only.
*/
`timescale 1ns/1ps
module mpdb_host_model (
  input wire logic core_clk,
  input wire logic [15:0] reg_rdata,
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic power_down_pin_n
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    power_down_pin_n = 1'b1;
  end
  // Released lines show the inverse, so stale values cannot pass
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
  task automatic pin(input logic v);
    @(posedge core_clk);
    power_down_pin_n <= v;
  endtask
endmodule

/* File: sim/mpdb_power_ctrl_properties.sv */
/*
 Checker for the power-down and balance control block.
 Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
module mpdb_power_ctrl_properties #(
  parameter int unsigned MINUTE_CYCLES = 10,
  parameter int unsigned CELLS = 6
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic power_down_pin_n,
  input wire logic [CELLS-1:0] balance_gate_output,
  input wire logic analog_enable,
  input wire logic digital_enable,
  input wire logic regulator_enable,
  input wire logic chain_enable,
  input wire logic thermistor_termination_input_en,
  input wire logic [1:0] readback_select,
  input wire mpdb_pkg::mpdb_conv_cfg_s conv_cfg
);
  logic [15:0] ctl_q;
  logic [15:0] alr_q;
  logic ctl_wr;
  logic alr_wr;
  logic [5:0] t_en;
  logic [3:0] n_conv;
  assign ctl_wr = reg_wr && reg_addr == 4'hd;
  assign alr_wr = reg_wr && reg_addr == 4'he;
  assign t_en = ctl_q[15:14] == 2'b00 ? 6'h3f :
                ctl_q[15:14] == 2'b01 ? 6'h15 : 6'h00;
  assign n_conv = ctl_q[15:14] == 2'b00 ? 4'hc : ctl_q[15:14] == 2'b01 ?
                  4'h9 : ctl_q[15:14] == 2'b10 ? 4'h6 : 4'h1;
  // Shadow of the last word written, so checks need no deep $past
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= 16'h0000;
      alr_q <= 16'h0000;
    end else begin
      if (ctl_wr) begin
        ctl_q <= reg_wdata;
      end
      if (alr_wr) begin
        alr_q <= reg_wdata;
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  sequence s_ctl;
    ctl_wr ##1 !ctl_wr;
  endsequence
  property p_enables_pair;
    analog_enable == digital_enable;
  endproperty
  property p_chain_kept;
    chain_enable == regulator_enable && (regulator_enable || !analog_enable);
  endproperty
  property p_gates_off;
    !analog_enable |-> balance_gate_output == '0;
  endproperty
  property p_gate_follow;
    reg_wr && reg_addr == 4'h1 && analog_enable && power_down_pin_n |=>
      (balance_gate_output == $past(reg_wdata[CELLS-1:0]) || !analog_enable);
  endproperty
  property p_conv;
    s_ctl |=> conv_cfg.conv_count == n_conv;
  endproperty
  property p_temp;
    s_ctl |=> conv_cfg.temp_en == t_en;
  endproperty
  property p_acq;
    s_ctl |=> conv_cfg.acq_cycles == {2'b00, ctl_q[6:5], 2'b00} + 6'h04;
  endproperty
  property p_rdbk;
    s_ctl |=> readback_select == ctl_q[13:12];
  endproperty
  property p_alert;
    (alr_wr && !ctl_wr) ##1 !(alr_wr || ctl_wr) |=> (conv_cfg.temp_alert_en &
      (alr_q[0] ? 6'h10 : alr_q[1] ? 6'h14 : 6'h00)) == 6'h00;
  endproperty
  a_enables_pair: assert property (p_enables_pair)
    else $error("enables");
  a_chain_kept: assert property (p_chain_kept)
    else $error("chain off");
  a_gates_off: assert property (p_gates_off)
    else $error("gates on");
  a_gate_follow: assert property (p_gate_follow)
    else $error("gates");
  a_conv: assert property (p_conv)
    else $error("conv count");
  a_temp: assert property (p_temp)
    else $error("temp enable");
  a_acq: assert property (p_acq)
    else $error("acquisition");
  a_rdbk: assert property (p_rdbk)
    else $error("readback");
  a_alert: assert property (p_alert)
    else $error("alert mask");
  c_sw_down: cover property (!analog_enable && regulator_enable);
  c_full_down: cover property (!regulator_enable);
  c_gates_drop: cover property ($fell(balance_gate_output[0]));
endmodule

/* File: sim/tb_mpdb_power_ctrl.sv */
/*
 Self-checking bench for the power-down and balance control block.
 Assumes a short minute so the delay timer runs in a few cycles.
*/
`timescale 1ns/1ps
module tb_mpdb_power_ctrl;
  localparam int unsigned MIN_CYC = 10;
  logic core_clk;
  logic rst_n;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic power_down_pin_n;
  logic [5:0] bgo;
  logic ana, dig, reg_en, chn, term;
  logic [1:0] rdbk;
  mpdb_pkg::mpdb_conv_cfg_s cfg;
  logic [15:0] rv;
  int failures;
  int samples_checked;
  mpdb_power_ctrl #(.MINUTE_CYCLES(MIN_CYC), .CELLS(6)) u_mpdb_power_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .power_down_pin_n(power_down_pin_n),
    .balance_gate_output(bgo), .analog_enable(ana), .digital_enable(dig),
    .regulator_enable(reg_en), .chain_enable(chn),
    .thermistor_termination_input_en(term), .readback_select(rdbk),
    .conv_cfg(cfg));
  mpdb_host_model u_mpdb_host_model (
    .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .power_down_pin_n(power_down_pin_n));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Bounded wait; the bench only asks for the level it expects next
  task automatic settle(input logic want, input int n);
    for (int k = 0; k < n && ana !== want; k++) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({10'h0, bgo}, 16'h0000);
    u_mpdb_host_model.rd(4'h1, rv);
    chk(rv, 16'h0000);
    u_mpdb_host_model.rd(4'h2, rv);
    chk(rv, 16'h0000);
    chk({10'h0, cfg.acq_cycles}, 16'h0004);
  endtask
  task automatic t_conv;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      u_mpdb_host_model.wr(4'hd, {c, c, 5'h00, c, 5'h00});
      repeat (2) @(posedge core_clk);
      #1;
      chk({12'h0, cfg.conv_count}, i == 0 ? 16'hc : i == 1 ? 16'h9 :
          i == 2 ? 16'h6 : 16'h1);
      chk({10'h0, cfg.temp_en},
          i == 0 ? 16'h3f : i == 1 ? 16'h15 : 16'h0);
      chk({10'h0, cfg.volt_en}, i == 3 ? 16'h0 : 16'h3f);
      chk({15'h0, cfg.self_test}, i == 3 ? 16'h1 : 16'h0);
      chk({10'h0, cfg.acq_cycles}, 16'h4 * (i + 1));
      chk({14'h0, rdbk}, {14'h0, c});
    end
    // Few thermistors in use: three temperatures converted and read back
    u_mpdb_host_model.wr(4'hd, 16'h5000);
    repeat (2) @(posedge core_clk);
    #1;
    chk({12'h0, cfg.conv_count}, 16'h9);
    chk({14'h0, rdbk}, 16'h0001);
    u_mpdb_host_model.wr(4'hd, 16'h0068);
    u_mpdb_host_model.wr(4'he, 16'h0001);
    repeat (2) @(posedge core_clk);
    #1;
    chk({10'h0, cfg.temp_alert_en}, 16'h002f);
    u_mpdb_host_model.wr(4'he, 16'h0002);
    repeat (2) @(posedge core_clk);
    #1;
    chk({15'h0, term}, 16'h0001);
    chk({10'h0, cfg.temp_alert_en}, 16'h002b);
    // A stray write with bit 8 set must not power anything down
    u_mpdb_host_model.wr(4'h7, 16'hffff);
    u_mpdb_host_model.rd(4'h7, rv);
    chk(rv, 16'h0000);
    chk({14'h0, ana, dig}, 16'h0003);
    u_mpdb_host_model.wr(4'hd, 16'h0000);
  endtask
  task automatic t_sw;
    u_mpdb_host_model.wr(4'h1, 16'h003f);
    #1;
    chk({10'h0, bgo}, 16'h003f);
    u_mpdb_host_model.wr(4'hd, 16'h0100);
    #1;
    chk({10'h0, bgo}, 16'h0000);
    chk({12'h0, ana, dig, reg_en, chn}, 16'h0003);
    u_mpdb_host_model.rd(4'h3, rv);
    chk({14'h0, rv[1:0]}, 16'h0002);
    u_mpdb_host_model.wr(4'hd, 16'h0000);
    settle(1'b1, 3);
    chk({15'h0, ana}, 16'h0001);
  endtask
  task automatic t_delay;
    u_mpdb_host_model.wr(4'h2, 16'h001f);
    u_mpdb_host_model.rd(4'h2, rv);
    chk(rv, 16'h001f);
    u_mpdb_host_model.wr(4'h2, 16'h0002);
    u_mpdb_host_model.wr(4'h1, 16'h0015);
    u_mpdb_host_model.pin(1'b0);
    // Still short of two minutes after the falling edge
    repeat (2 * MIN_CYC - 1) @(posedge core_clk);
    #1;
    chk({10'h0, bgo}, 16'h0015);
    chk({15'h0, ana}, 16'h0001);
    u_mpdb_host_model.rd(4'h3, rv);
    chk({13'h0, rv[2:0]}, 16'h0005);
    settle(1'b0, 12);
    chk({10'h0, bgo}, 16'h0000);
    chk({14'h0, reg_en, chn}, 16'h0000);
    u_mpdb_host_model.pin(1'b1);
    // Reference settling wait scaled down; no conversion is started here
    repeat (4) @(posedge core_clk);
    #1;
    chk({15'h0, ana}, 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #100us;
    failures++;
    test_done();
  end
  initial begin
    failures = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_conv();
    t_sw();
    t_delay();
    test_done();
  end
endmodule
bind mpdb_power_ctrl mpdb_power_ctrl_properties #(
  .MINUTE_CYCLES(MINUTE_CYCLES), .CELLS(CELLS)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .power_down_pin_n(power_down_pin_n),
  .balance_gate_output(balance_gate_output),
  .analog_enable(analog_enable), .digital_enable(digital_enable),
  .regulator_enable(regulator_enable), .chain_enable(chain_enable),
  .thermistor_termination_input_en(thermistor_termination_input_en),
  .readback_select(readback_select), .conv_cfg(conv_cfg));
